/* ics_defs.vh */
/*
 * Constants for the eight-channel two-wire bus switch control logic.
 * Assumes a 125 MHz system clock that oversamples the upstream bus.
 */
`ifndef ICS_DEFS_VH
`define ICS_DEFS_VH

`define ICS_CHANNELS      8
`define ICS_ADDR_HI       4'hE
`define ICS_SEL_RESET     8'h00
`define ICS_BIT_LAST      4'h7
`define ICS_BIT_FULL      4'h8
`define ICS_BIT_ZERO      4'h0
`define ICS_BIT_ONE       4'h1
`define ICS_LINE_LOW      1'b0

`define ICS_CLK_MHZ       125
`define ICS_T_RST_NS      500
`define ICS_T_RST_CYC     ((`ICS_T_RST_NS * `ICS_CLK_MHZ) / 1000)
`define ICS_SCL_STD_KHZ   100
`define ICS_SCL_FAST_KHZ  400

`define ICS_ST_IDLE       3'h0
`define ICS_ST_ADDR       3'h1
`define ICS_ST_ADDR_ACK   3'h2
`define ICS_ST_WDATA      3'h3
`define ICS_ST_WACK       3'h4
`define ICS_ST_RDATA      3'h5
`define ICS_ST_RACK       3'h6

`endif

/* ics_sync.v */
/*
 * Two-flop synchroniser for a group of level inputs.
 * Assumes inputs are asynchronous to clock; the first stage feeds only
 * the second.
 */
`timescale 1ns/1ps
module ics_sync #(
  parameter         W         = 1,
  parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
  input  wire         clock,
  input  wire         rst,
  input  wire         clk_en,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] stage1;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (clk_en) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

/* ics_ctrl.v */
/*
 * Target-side control of an eight-channel two-wire bus switch: address
 * match, one channel-select register, channel enables and reset handling.
 * Assumes clock oversamples the upstream serial clock by far (fast mode);
 * rst is the power-on reset; analog pass gates sit outside.
 */
`timescale 1ns/1ps
`include "ics_defs.vh"
module ics_ctrl #(
  parameter N = `ICS_CHANNELS
) (
  input  wire         clock,
  input  wire         rst,
  input  wire         clk_en,
  input  wire         reset_n,
  input  wire         scl_in,
  input  wire         sda_in,
  output wire         sda_out,
  output reg          sda_oe,
  input  wire         addr_select_bit0,
  input  wire         addr_select_bit1,
  input  wire         addr_select_bit2,
  output reg  [N-1:0] channel_connect,
  output wire [N-1:0] downstream_clock_line_out,
  output reg  [N-1:0] downstream_clock_line_oe,
  output wire [N-1:0] downstream_data_line_out,
  output reg  [N-1:0] downstream_data_line_oe
);
  reg   [2:0] state;
  reg   [3:0] bit_cnt;
  reg   [7:0] shift;
  reg   [7:0] channel_select;
  reg         pending;
  reg         rw_read;
  reg         scl_d;
  reg         sda_d;
  reg         reset_hit;
  wire        scl_s;
  wire        sda_s;
  wire [2:0]  addr_s;
  wire        reset_req;

  assign sda_out                   = `ICS_LINE_LOW;
  assign downstream_clock_line_out = {N{`ICS_LINE_LOW}};
  assign downstream_data_line_out  = {N{`ICS_LINE_LOW}};

  // a reset pulse shorter than a clock period is caught asynchronously
  always @(posedge clock or posedge rst or negedge reset_n) begin
    if (rst)
      reset_hit <= 1'b0;
    else if (!reset_n)
      reset_hit <= 1'b1;
    else if (clk_en && reset_req)
      reset_hit <= 1'b0;
  end

  ics_sync #(.W(1), .RESET_VAL(1'b0)) u_sync_rst (
    .clock    (clock),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (reset_hit),
    .sync_out (reset_req)
  );

  ics_sync #(.W(2), .RESET_VAL(2'h3)) u_sync_bus (
    .clock    (clock),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in ({scl_in, sda_in}),
    .sync_out ({scl_s, sda_s})
  );

  ics_sync #(.W(3), .RESET_VAL(3'h0)) u_sync_addr (
    .clock    (clock),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in ({addr_select_bit2, addr_select_bit1, addr_select_bit0}),
    .sync_out (addr_s)
  );

  // edges come from oversampling, so any rate up to fast mode is taken
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
  wire addr_hit  = (shift[7:1] == {`ICS_ADDR_HI, addr_s});

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_d                    <= 1'b1;
      sda_d                    <= 1'b1;
      downstream_clock_line_oe <= {N{1'b0}};
      downstream_data_line_oe  <= {N{1'b0}};
    end else if (clk_en) begin
      scl_d                    <= scl_s;
      sda_d                    <= sda_s;
      // upstream lows pass to every connected channel
      downstream_clock_line_oe <= channel_connect & {N{~scl_s}};
      downstream_data_line_oe  <= channel_connect & {N{~sda_s}};
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state           <= `ICS_ST_IDLE;
      bit_cnt         <= `ICS_BIT_ZERO;
      shift           <= `ICS_SEL_RESET;
      channel_select  <= `ICS_SEL_RESET;
      channel_connect <= {N{1'b0}};
      pending         <= 1'b0;
      rw_read         <= 1'b0;
      sda_oe          <= 1'b0;
    end else if (clk_en) begin
      if (reset_req) begin
        state           <= `ICS_ST_IDLE;
        channel_select  <= `ICS_SEL_RESET;
        channel_connect <= {N{1'b0}};
        pending         <= 1'b0;
        sda_oe          <= 1'b0;
        bit_cnt         <= `ICS_BIT_ZERO;
      end else if (bus_stop) begin
        state  <= `ICS_ST_IDLE;
        sda_oe <= 1'b0;
        if (pending)
          channel_connect <= channel_select[N-1:0];
        pending <= 1'b0;
      end else if (bus_start) begin
        state   <= `ICS_ST_ADDR;
        bit_cnt <= `ICS_BIT_ZERO;
        sda_oe  <= 1'b0;
      end else begin
        case (state)
          `ICS_ST_ADDR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + `ICS_BIT_ONE;
            end else if (scl_fall && bit_cnt == `ICS_BIT_FULL) begin
              if (addr_hit) begin
                state   <= `ICS_ST_ADDR_ACK;
                rw_read <= shift[0];
                sda_oe  <= 1'b1;
              end else begin
                state <= `ICS_ST_IDLE;
              end
            end
          end
          `ICS_ST_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= `ICS_BIT_ZERO;
              if (rw_read) begin
                state  <= `ICS_ST_RDATA;
                shift  <= channel_select;
                sda_oe <= ~channel_select[7];
              end else begin
                state  <= `ICS_ST_WDATA;
                sda_oe <= 1'b0;
              end
            end
          end
          `ICS_ST_WDATA: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + `ICS_BIT_ONE;
            end else if (scl_fall && bit_cnt == `ICS_BIT_FULL) begin
              channel_select <= shift;
              pending        <= 1'b1;
              state          <= `ICS_ST_WACK;
              sda_oe         <= 1'b1;
            end
          end
          `ICS_ST_WACK: begin
            if (scl_fall) begin
              state   <= `ICS_ST_WDATA;
              bit_cnt <= `ICS_BIT_ZERO;
              sda_oe  <= 1'b0;
            end
          end
          `ICS_ST_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == `ICS_BIT_LAST) begin
                state  <= `ICS_ST_RACK;
                sda_oe <= 1'b0;
              end else begin
                bit_cnt <= bit_cnt + `ICS_BIT_ONE;
                shift   <= {shift[6:0], 1'b0};
                sda_oe  <= ~shift[6];
              end
            end
          end
          `ICS_ST_RACK: begin
            if (scl_rise && sda_s) begin
              state <= `ICS_ST_IDLE;
            end else if (scl_fall) begin
              state   <= `ICS_ST_RDATA;
              bit_cnt <= `ICS_BIT_ZERO;
              shift   <= channel_select;
              sda_oe  <= ~channel_select[7];
            end
          end
          default: begin
            state  <= `ICS_ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

/* ics_ctrl_properties.sv */
/* port checker for the bus switch control block
   assumes it is bound to ics_ctrl and sees one clock domain */
`timescale 1ns/1ps
module ics_ctrl_chk #(
  parameter N = 8
) (
  input wire         clock,
  input wire         rst,
  input wire         clk_en,
  input wire         reset_n,
  input wire         scl_in,
  input wire         sda_in,
  input wire         sda_oe,
  input wire [N-1:0] channel_connect,
  input wire [N-1:0] downstream_clock_line_oe,
  input wire [N-1:0] downstream_data_line_oe
);
  reg [3:0] since_stop;
  // cycles since data rose while the clock was high
  always @(posedge clock or posedge rst) begin
    if (rst)
      since_stop <= 4'hF;
    else if (scl_in && $rose(sda_in))
      since_stop <= 4'h0;
    else if (since_stop != 4'hF)
      since_stop <= since_stop + 4'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_pin_rst; $fell(reset_n) && clk_en; endsequence
  sequence s_scl_low; !scl_in [*5] ##0 $stable(channel_connect); endsequence
  property p_release; s_pin_rst |-> ##[1:62] !sda_oe; endproperty
  a_release: assert property (p_release)
    else $error("data line held after reset pin");
  property p_clear; s_pin_rst |-> ##[1:6] channel_connect == 0; endproperty
  a_clear: assert property (p_clear)
    else $error("channels kept after reset pin");
  property p_por; $fell(rst) |-> channel_connect == 0 && !sda_oe; endproperty
  a_por: assert property (p_por)
    else $error("state not clear after power-on");
  property p_ack; $rose(sda_oe) |-> !scl_in; endproperty
  a_ack: assert property (p_ack)
    else $error("data pulled low with clock high");
  property p_sel; $changed(channel_connect) && |channel_connect
    |-> since_stop < 4'h8; endproperty
  a_sel: assert property (p_sel)
    else $error("selection applied without stop");
  property p_gate; ((downstream_clock_line_oe | downstream_data_line_oe)
    & ~(channel_connect | $past(channel_connect))) == 0; endproperty
  a_gate: assert property (p_gate)
    else $error("closed channel driven");
  property p_hi; scl_in [*5] |-> downstream_clock_line_oe == 0; endproperty
  a_hi: assert property (p_hi)
    else $error("channel clock held low");
  property p_lo; s_scl_low |-> downstream_clock_line_oe == channel_connect;
  endproperty
  a_lo: assert property (p_lo)
    else $error("channel clock not following");
endmodule

/* ics_host.sv */
/* upstream bus controller model
   assumes pull-ups on the data line; clock line always driven */
`timescale 1ns/1ps
module ics_host (
  input  wire clock,
  input  wire sda,
  output reg  scl,
  output reg  sda_drv
);
  reg     r;
  integer k;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // data moves two cycles after the clock line
  task drive(input c, input d); begin
    scl = c;
    repeat (2) @(negedge clock);
    sda_drv = d;
    repeat (8) @(negedge clock);
  end endtask
  task bitx(input b, output v); begin
    drive(1'b0, b);
    drive(1'b1, b);
    v = sda;
  end endtask
  task start; begin
    drive(scl, 1'b1);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
    drive(1'b0, 1'b0);
  end endtask
  task stop; begin
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
  end endtask
  task wbyte(input [7:0] b, output a); begin
    for (k = 7; k >= 0; k = k - 1)
      bitx(b[k], r);
    bitx(1'b1, a);
    drive(1'b0, 1'b1);
  end endtask
  task rbyte(output [7:0] d, input n); begin
    for (k = 7; k >= 0; k = k - 1) begin
      bitx(1'b1, r);
      d[k] = r;
    end
    bitx(n, r);
    drive(1'b0, 1'b1);
  end endtask
endmodule

/* tb.sv */
/* testbench for the bus switch control block
   assumes ics_host drives the upstream lines, pull-up on data */
`timescale 1ns/1ps
module tb;
  reg        clock;
  reg        rst;
  reg        clk_en;
  reg        reset_n;
  reg  [2:0] pins;
  reg        ack;
  reg  [7:0] rd;
  wire       scl;
  wire       sda_drv;
  wire       sda_oe;
  wire [7:0] cc;
  wire       sda = sda_drv & ~sda_oe;
  integer    mismatches = 0;
  integer    n_checks = 0;
  integer    i;
  ics_ctrl dut_u (.clock(clock), .rst(rst), .clk_en(clk_en),
    .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .addr_select_bit0(pins[0]),
    .addr_select_bit1(pins[1]), .addr_select_bit2(pins[2]),
    .channel_connect(cc), .downstream_clock_line_out(),
    .downstream_clock_line_oe(), .downstream_data_line_out(),
    .downstream_data_line_oe());
  ics_host host_u (.clock(clock), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task check(input [7:0] seen, input [7:0] exp); begin
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end endtask
  task end_of_test; begin
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end endtask
  task write(input [7:0] a, input [7:0] d); begin
    host_u.start;
    host_u.wbyte(a, ack);
    host_u.wbyte(d, ack);
    host_u.stop;
    repeat (8) @(negedge clock);
  end endtask
  task t_addr; begin
    for (i = 0; i < 8; i = i + 1) begin
      pins = i[2:0];
      host_u.start;
      host_u.wbyte({4'hE, i[2:0] ^ 3'h5, 1'b0}, ack);
      check({7'h0, ack}, 8'h01);
      write({4'hE, i[2:0], 1'b0}, 8'h01 << i);
      check({7'h0, ack}, 8'h00);
      check(cc, 8'h01 << i);
    end
  end endtask
  task t_write; begin
    pins = 3'h0;
    host_u.start;
    host_u.wbyte(8'hE0, ack);
    host_u.wbyte(8'hA5, ack);
    host_u.wbyte(8'h3C, ack);
    check(cc, 8'h80);
    host_u.stop;
    repeat (8) @(negedge clock);
    check(cc, 8'h3C);
  end endtask
  task t_read; begin
    host_u.start;
    host_u.wbyte(8'hE1, ack);
    host_u.rbyte(rd, 1'b0);
    check(rd, 8'h3C);
    host_u.rbyte(rd, 1'b1);
    check(rd, 8'h3C);
    host_u.stop;
  end endtask
  task t_reset; begin
    write(8'hE0, 8'h7F);
    check(cc, 8'h7F);
    host_u.start;
    host_u.wbyte(8'hE1, ack);
    reset_n = 1'b0;
    #6 reset_n = 1'b1;
    repeat (8) @(negedge clock);
    check(cc, 8'h00);
    check({7'h0, sda_oe}, 8'h00);
    write(8'hE0, 8'h00);
    check({7'h0, ack}, 8'h00);
  end endtask
  task t_freeze; begin
    clk_en = 1'b0;
    write(8'hE0, 8'h55);
    clk_en = 1'b1;
    repeat (8) @(negedge clock);
    check(cc, 8'h00);
    write(8'hE0, 8'hA3);
    check(cc, 8'hA3);
  end endtask
  initial begin
    #200000;
    mismatches = mismatches + 1;
    end_of_test;
  end
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    reset_n = 1'b1;
    pins = 3'h0;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check(cc, 8'h00);
    t_addr;
    t_write;
    t_read;
    t_reset;
    t_freeze;
    end_of_test;
  end
endmodule
bind ics_ctrl ics_ctrl_chk #(.N(N)) chk_u (.clock(clock), .rst(rst),
  .clk_en(clk_en), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe(sda_oe), .channel_connect(channel_connect),
  .downstream_clock_line_oe(downstream_clock_line_oe),
  .downstream_data_line_oe(downstream_data_line_oe));
